/* rtl/csb_pkg.sv */
package csb_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int DEPTH = 8192;
    localparam logic [12:0] CONTROL_ADDR = 13'h1FF8;
    localparam logic [12:0] SECONDS_ADDR = 13'h1FF9;
    localparam logic [12:0] MINUTES_ADDR = 13'h1FFA;
    localparam logic [12:0] HOURS_ADDR = 13'h1FFB;
    localparam logic [12:0] WEEKDAY_ADDR = 13'h1FFC;
    localparam logic [12:0] DATE_ADDR = 13'h1FFD;
    localparam logic [12:0] MONTH_ADDR = 13'h1FFE;
    localparam logic [12:0] YEAR_ADDR = 13'h1FFF;
    localparam int CTL_WRITE_BIT = 7;
    localparam int CTL_READ_BIT = 6;
    localparam int CTL_SIGN_BIT = 5;
    localparam int OSC_HALT_BIT = 7;
    localparam int FREQ_TEST_BIT = 6;
    localparam int CLOCK_MHZ = 125;
    localparam int CLOCK_HZ = 125000000;
    // Times in ns, us and ms as the names say, figures as printed
    localparam int ADDRESS_ACCESS_TIME_NS = 100;
    localparam int OUTPUT_HOLD_TIME_NS = 5;
    localparam int WRITE_TO_FLOAT_TIME_NS = 50;
    localparam int DESELECT_DELAY_MIN_US = 10;
    localparam int DESELECT_DELAY_MAX_US = 40;
    localparam int IRQ_RELEASE_DELAY_US = 120;
    localparam int POWER_UP_RECOVERY_MS = 1;
    // Access time rounds up; hold and float times round down, hold to at least one cycle
    localparam int ACCESS_CYCLES = (ADDRESS_ACCESS_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam int HOLD_CYCLES = (OUTPUT_HOLD_TIME_NS * CLOCK_MHZ) / 1000 < 1 ? 1
                                 : (OUTPUT_HOLD_TIME_NS * CLOCK_MHZ) / 1000;
    localparam int FLOAT_CYCLES = (WRITE_TO_FLOAT_TIME_NS * CLOCK_MHZ) / 1000;
    localparam int DESELECT_CYCLES = DESELECT_DELAY_MIN_US * CLOCK_MHZ;
    localparam int IRQ_RELEASE_CYCLES = IRQ_RELEASE_DELAY_US * CLOCK_MHZ;
    localparam int RECOVERY_CYCLES = POWER_UP_RECOVERY_MS * 1000 * CLOCK_MHZ;
    localparam int SECOND_CYCLES = CLOCK_HZ;
    localparam int CNT_W = 32;

    typedef struct packed {
        logic select_low_active_n;
        logic select_high_active;
        logic output_enable_n;
        logic write_strobe_n;
        logic [ADDR_W-1:0] address_lines;
    } csb_bus_type;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] weekday;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } csb_time_type;
endpackage : csb_pkg

/* rtl/csb_time_counter.sv */
`timescale 1ns/1ps
module csb_time_counter
    import csb_pkg::*;
#(
    parameter int SECOND_TICKS = SECOND_CYCLES
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic halt,
    input wire logic load,
    input csb_pkg::csb_time_type load_value,
    output csb_pkg::csb_time_type count,
    output logic tick
);
    import csb_pkg::*;

    // ************************************************************
    // Free-running BCD calendar
    // ************************************************************
    logic [CNT_W-1:0] div_reg;
    csb_time_type count_reg;
    csb_time_type inc;
    logic wrap_sec, wrap_min, wrap_hour, wrap_date, wrap_month;
    logic [7:0] last_day;
    logic leap;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic wrap, input logic [7:0] first);
        if (wrap)
            return first;
        if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // Year BCD divisible by four; century years count as leap
    assign leap = (count_reg.year[4] == 1'b0) ? (count_reg.year[1:0] == 2'b00)
                                              : (count_reg.year[1:0] == 2'b10);
    assign last_day = (count_reg.month == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                      (count_reg.month == 8'h04 || count_reg.month == 8'h06 ||
                       count_reg.month == 8'h09 || count_reg.month == 8'h11) ? 8'h30 : 8'h31; // [RQ25]
    assign wrap_sec = count_reg.seconds[6:0] == 7'h59;
    assign wrap_min = count_reg.minutes[6:0] == 7'h59;
    assign wrap_hour = count_reg.hours[5:0] == 6'h23;
    assign wrap_date = count_reg.date[5:0] >= last_day[5:0];
    assign wrap_month = count_reg.month[4:0] == 5'h12;

    always_comb
    begin
        inc = count_reg;
        inc.seconds = {count_reg.seconds[7], 7'(bcd_inc({1'b0, count_reg.seconds[6:0]}, wrap_sec, 8'h00))};
        if (wrap_sec)
        begin
            inc.minutes = bcd_inc(count_reg.minutes, wrap_min, 8'h00);
            if (wrap_min)
            begin
                inc.hours = bcd_inc(count_reg.hours, wrap_hour, 8'h00);
                if (wrap_hour)
                begin
                    inc.weekday = {count_reg.weekday[7:3] & 5'h08,
                                   (count_reg.weekday[2:0] == 3'h7) ? 3'h1 : count_reg.weekday[2:0] + 3'h1};
                    inc.date = bcd_inc(count_reg.date, wrap_date, 8'h01); // [RQ25]
                    if (wrap_date)
                    begin
                        inc.month = bcd_inc(count_reg.month, wrap_month, 8'h01);
                        if (wrap_month)
                            inc.year = bcd_inc(count_reg.year, count_reg.year == 8'h99, 8'h00);
                    end
                end
            end
        end
    end

    assign tick = (div_reg == CNT_W'(SECOND_TICKS - 1));

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            div_reg <= '0;
            count_reg <= '0;
        end
        else if (load)
        begin
            div_reg <= '0;
            count_reg <= load_value;
        end
        else if (!halt)
        begin
            div_reg <= tick ? '0 : div_reg + CNT_W'(1);
            if (tick)
                count_reg <= inc;
        end
    end

    assign count = count_reg;
endmodule : csb_time_counter

/* rtl/csb_clock_sram.sv */
`timescale 1ns/1ps
// Behaviour
// (RQ1) Write strobe high, low select low, high select high means read.
// (RQ2) Thirteen address lines pick one of 8192 byte locations.
// (RQ3) Read data valid only after address, select and enable access times; code counts only ACCESS_CYCLES from select and address.
// (RQ4) Data lines driven only when both selects and output enable active.
// (RQ5) Outputs enabled before address access time show indeterminate data.
// (RQ6) Address change keeps old data for hold time, then indeterminate.
// (RQ7) Write starts at last of the three strobes becoming active.
// (RQ8) Write ends at first strobe going inactive; data captured then.
// (RQ9) Master holds address stable through the whole write.
// (RQ10) Master keeps strobes inactive for recovery before next cycle.
// (RQ11) Master gives write data set-up before and hold after end.
// (RQ12) Output enable high during writes; else outputs release after strobe falls.
// (RQ13) Time bytes hold BCD values at 1FF9h through 1FFFh.
// (RQ14) Control byte holds write, read, sign, calibration; halt and test bits.
// (RQ15) Software writes zero to frequency-test bit normally.
// (RQ16) Software writes zero to bits marked zero.
// (RQ17) Power fail deselects, blocks writes, floats outputs, ignores inputs.
// (RQ18) After power fail clears, block accesses for recovery interval.
// (RQ19) Master keeps selects inactive while supply returns.
// (RQ20) Power fail asserts interrupt low immediately.
// (RQ21) Deselect follows interrupt after 10 to 40 microseconds.
// (RQ22) Interrupt pin is open drain, never driven high.
// (RQ23) Interrupt released within 120 microseconds after supply recovers.
// (RQ24) Clock bytes refreshed from true counters once per second.
// (RQ25) Date rolls correctly for 28, 29, 30 and 31 day months.
// (RQ26) Supply fault is a synchronous input triggering interrupt and deselect.
// (RQ27) Addresses below clock bytes are plain memory without side effects.
module csb_clock_sram
    import csb_pkg::*;
#(
    parameter int DESELECT_TICKS = DESELECT_CYCLES,
    parameter int RELEASE_TICKS = IRQ_RELEASE_CYCLES,
    parameter int RECOVERY_TICKS = RECOVERY_CYCLES,
    parameter int SECOND_TICKS = SECOND_CYCLES
)
(
    input wire logic clock,
    input wire logic rstn,
    input csb_pkg::csb_bus_type bus,
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    output logic data_valid,
    input wire logic supply_fault,
    output logic power_fail_irq_out,
    output logic power_fail_irq_oe
);
    import csb_pkg::*;

    // ************************************************************
    // Power-fail sequencing
    // ************************************************************
    typedef enum logic [1:0] {PF_NORMAL, PF_WARN, PF_DESELECT, PF_RECOVER} csb_pf_type;
    csb_pf_type pf_reg, pf_next;
    logic [CNT_W-1:0] pf_cnt_reg;
    logic irq_reg;
    logic pf_done;
    logic blocked;

    assign pf_done = (pf_cnt_reg == '0);
    // Ignore the bus in deselect and recover states [RQ17] [RQ18]
    assign blocked = (pf_reg != PF_NORMAL) && (pf_reg != PF_WARN);

    always_comb
    begin
        pf_next = pf_reg;
        unique case (pf_reg)
            PF_NORMAL: if (supply_fault) pf_next = PF_WARN; // [RQ26]
            PF_WARN: if (pf_done) pf_next = PF_DESELECT; // [RQ21]
            PF_DESELECT: if (!supply_fault) pf_next = PF_RECOVER;
            PF_RECOVER:
            begin
                if (supply_fault)
                    pf_next = PF_DESELECT;
                else if (pf_done)
                    pf_next = PF_NORMAL; // [RQ18]
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            pf_reg <= PF_NORMAL;
            pf_cnt_reg <= '0;
        end
        else
        begin
            pf_reg <= pf_next;
            if (pf_reg == PF_NORMAL && supply_fault)
                pf_cnt_reg <= CNT_W'(DESELECT_TICKS - 1); // [RQ21]
            else if (pf_reg == PF_DESELECT && !supply_fault)
                pf_cnt_reg <= CNT_W'(RECOVERY_TICKS - 1); // [RQ18]
            else if (!pf_done)
                pf_cnt_reg <= pf_cnt_reg - CNT_W'(1);
        end
    end

    // ************************************************************
    // Interrupt pin
    // ************************************************************
    logic [CNT_W-1:0] rel_cnt_reg;

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            irq_reg <= 1'b0;
            rel_cnt_reg <= '0;
        end
        else if (supply_fault)
        begin
            irq_reg <= 1'b1; // [RQ20]
            rel_cnt_reg <= CNT_W'(RELEASE_TICKS - 1);
        end
        else if (rel_cnt_reg != '0)
            rel_cnt_reg <= rel_cnt_reg - CNT_W'(1);
        else
            irq_reg <= 1'b0; // [RQ23]
    end

    // Pin value is constant low; only the enable moves [RQ22]
    assign power_fail_irq_out = 1'b0;
    assign power_fail_irq_oe = irq_reg;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic selected;
    logic write_active;
    logic read_mode;
    logic write_prev_reg;
    logic write_end;
    logic [ADDR_W-1:0] addr_prev_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [DATA_W-1:0] wr_data_reg;

    assign selected = !bus.select_low_active_n && bus.select_high_active && !blocked; // [RQ17]
    assign write_active = selected && !bus.write_strobe_n; // [RQ7]
    assign read_mode = selected && bus.write_strobe_n; // [RQ1]
    assign write_end = write_prev_reg && !write_active; // [RQ8]

    // Address and data taken each cycle of the write; the last one counts [RQ8]
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            write_prev_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
            addr_prev_reg <= '0;
        end
        else
        begin
            // Power loss mid-write drops the write, matching corrupt-location tolerance
            write_prev_reg <= write_active && !blocked;
            addr_prev_reg <= bus.address_lines;
            if (write_active)
            begin
                wr_addr_reg <= bus.address_lines; // [RQ9]
                wr_data_reg <= data_lines_in; // [RQ11]
            end
        end
    end

    // ************************************************************
    // Storage
    // ************************************************************
    localparam int RAM_WORDS = DEPTH - 8;
    logic [DATA_W-1:0] mem [0:RAM_WORDS-1];
    logic [DATA_W-1:0] ctl_reg;
    csb_time_type shadow_reg;
    csb_time_type counter_value;
    logic sec_tick;
    logic commit_load;
    logic halt_updates;
    logic is_clock_addr;
    logic do_write;

    assign is_clock_addr = (wr_addr_reg >= CONTROL_ADDR);
    assign do_write = write_end && !blocked;
    // Clearing the write bit pushes the shadow bytes into the counters
    assign commit_load = do_write && wr_addr_reg == CONTROL_ADDR &&
                         ctl_reg[CTL_WRITE_BIT] && !wr_data_reg[CTL_WRITE_BIT];
    assign halt_updates = ctl_reg[CTL_WRITE_BIT] || ctl_reg[CTL_READ_BIT];

    csb_time_counter #(
        .SECOND_TICKS(SECOND_TICKS)
    ) u_counter (
        .clock(clock),
        .rstn(rstn),
        .halt(shadow_reg.seconds[OSC_HALT_BIT]),
        .load(commit_load),
        .load_value(shadow_reg),
        .count(counter_value),
        .tick(sec_tick)
    );

    // Plain memory below the clock bytes [RQ27] [RQ2]
    always_ff @(posedge clock)
    begin
        if (do_write && !is_clock_addr)
            mem[wr_addr_reg] <= wr_data_reg;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ctl_reg <= '0;
            shadow_reg <= '0;
        end
        else if (do_write && is_clock_addr)
        begin
            unique case (wr_addr_reg)
                CONTROL_ADDR: ctl_reg <= wr_data_reg; // [RQ14]
                SECONDS_ADDR: shadow_reg.seconds <= wr_data_reg; // [RQ13]
                MINUTES_ADDR: shadow_reg.minutes <= wr_data_reg;
                HOURS_ADDR: shadow_reg.hours <= wr_data_reg;
                WEEKDAY_ADDR: shadow_reg.weekday <= wr_data_reg;
                DATE_ADDR: shadow_reg.date <= wr_data_reg;
                MONTH_ADDR: shadow_reg.month <= wr_data_reg;
                default: shadow_reg.year <= wr_data_reg;
            endcase
        end
        else if (!halt_updates)
        begin
            // Refresh keeps the software halt bit; counts follow each second [RQ24]
            shadow_reg <= counter_value;
            shadow_reg.seconds[OSC_HALT_BIT] <= shadow_reg.seconds[OSC_HALT_BIT];
            shadow_reg.weekday[FREQ_TEST_BIT] <= shadow_reg.weekday[FREQ_TEST_BIT];
        end
    end

    // ************************************************************
    // Read path and output timing
    // ************************************************************
    logic [DATA_W-1:0] rd_byte;
    logic [7:0] access_cnt_reg;
    logic [7:0] float_cnt_reg;
    logic [7:0] hold_cnt_reg;
    logic addr_changed;
    logic drive_req;
    logic [DATA_W-1:0] out_reg;
    logic oe_reg;
    logic valid_reg;
    logic [DATA_W-1:0] held_reg;

    assign rd_byte = (bus.address_lines == CONTROL_ADDR) ? ctl_reg :
                     (bus.address_lines == SECONDS_ADDR) ? shadow_reg.seconds :
                     (bus.address_lines == MINUTES_ADDR) ? shadow_reg.minutes :
                     (bus.address_lines == HOURS_ADDR) ? shadow_reg.hours :
                     (bus.address_lines == WEEKDAY_ADDR) ? shadow_reg.weekday :
                     (bus.address_lines == DATE_ADDR) ? shadow_reg.date :
                     (bus.address_lines == MONTH_ADDR) ? shadow_reg.month :
                     (bus.address_lines == YEAR_ADDR) ? shadow_reg.year :
                     mem[bus.address_lines]; // [RQ2]
    assign addr_changed = bus.address_lines != addr_prev_reg;
    // Strobe falling with outputs on still drives until float time passes [RQ12]
    assign drive_req = selected && !bus.output_enable_n &&
                       (bus.write_strobe_n || float_cnt_reg != 8'h00); // [RQ4]

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            access_cnt_reg <= '0;
            float_cnt_reg <= '0;
            hold_cnt_reg <= '0;
            out_reg <= '0;
            oe_reg <= 1'b0;
            valid_reg <= 1'b0;
            held_reg <= '0;
        end
        else
        begin
            oe_reg <= drive_req;
            if (!read_mode || addr_changed)
                access_cnt_reg <= 8'(ACCESS_CYCLES); // [RQ3]
            else if (access_cnt_reg != 8'h00)
                access_cnt_reg <= access_cnt_reg - 8'h01;
            if (bus.write_strobe_n)
                float_cnt_reg <= 8'(FLOAT_CYCLES);
            else if (float_cnt_reg != 8'h00)
                float_cnt_reg <= float_cnt_reg - 8'h01;
            if (addr_changed && valid_reg)
                hold_cnt_reg <= 8'(HOLD_CYCLES); // [RQ6]
            else if (hold_cnt_reg != 8'h00)
                hold_cnt_reg <= hold_cnt_reg - 8'h01;
            if (read_mode && access_cnt_reg <= 8'h01 && !addr_changed)
            begin
                out_reg <= rd_byte;
                held_reg <= rd_byte;
                valid_reg <= drive_req;
            end
            else if (addr_changed && valid_reg)
            begin
                out_reg <= held_reg; // [RQ6]
                valid_reg <= drive_req;
            end
            else if (hold_cnt_reg > 8'h01)
                valid_reg <= drive_req;
            else
            begin
                // Indeterminate phase shown as all ones with valid low [RQ5]
                out_reg <= 8'hFF;
                valid_reg <= 1'b0;
            end
        end
    end

    assign data_lines_out = out_reg;
    assign data_lines_oe = oe_reg;
    // Valid only while driving, so the pin stays a plain flop
    assign data_valid = valid_reg;
endmodule : csb_clock_sram

/* tb/csb_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// Host bus master
// ****************************************
module csb_host_model
    import csb_pkg::*;
(
    input wire logic clock,
    input wire logic [csb_pkg::DATA_W-1:0] data_lines_out,
    input wire logic data_valid,
    output csb_pkg::csb_bus_type bus,
    output logic [csb_pkg::DATA_W-1:0] data_lines_in,
    output logic rd_done,
    output logic [csb_pkg::DATA_W-1:0] rd_data,
    output logic rd_timeout
);
    initial
    begin
        bus = {1'b1, 1'b0, 1'b1, 1'b1, 13'h0000};
        data_lines_in = 8'h00;
        rd_done = 1'b0;
        rd_data = 8'h00;
        rd_timeout = 1'b0;
    end
    task automatic idle();
        bus.select_low_active_n <= 1'b1;
        bus.select_high_active <= 1'b0;
        bus.output_enable_n <= 1'b1;
        bus.write_strobe_n <= 1'b1;
    endtask : idle
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= {1'b0, 1'b1, 1'b1, 1'b0, a}; // Output enable high while writing
        data_lines_in <= d; // Set up well before end of write
        repeat (2) @(posedge clock);
        bus.write_strobe_n <= 1'b1; // Address and data held past the end
        @(posedge clock);
        idle(); // Inactive gap before next cycle
        @(posedge clock);
        data_lines_in <= ~d; // Released lines never show the old byte
    endtask : wr
    task automatic rd(input logic [12:0] a);
        int n;
        n = 0;
        @(posedge clock);
        bus <= {1'b0, 1'b1, 1'b0, 1'b1, a};
        @(posedge clock);
        while (data_valid !== 1'b1 && n < 40)
        begin
            @(posedge clock);
            n++;
        end
        rd_data <= data_lines_out;
        rd_done <= 1'b1;
        rd_timeout <= (data_valid !== 1'b1);
        bus.address_lines <= a ^ 13'h0001; // Address moves while still selected
        @(posedge clock);
        rd_done <= 1'b0;
        rd_timeout <= 1'b0;
        repeat (2) @(posedge clock);
        idle();
    endtask : rd
endmodule : csb_host_model

/* tb/csb_clock_sram_asserts.sv */
`timescale 1ns/1ps
// ****************************************
// Port checks
// ****************************************
module csb_clock_sram_asserts
    import csb_pkg::*;
#(
    parameter int DESELECT_TICKS = DESELECT_CYCLES,
    parameter int RELEASE_TICKS = IRQ_RELEASE_CYCLES
)
(
    input wire logic clock,
    input wire logic rstn,
    input csb_pkg::csb_bus_type bus,
    input wire logic [csb_pkg::DATA_W-1:0] data_lines_in,
    input wire logic [csb_pkg::DATA_W-1:0] data_lines_out,
    input wire logic data_lines_oe,
    input wire logic data_valid,
    input wire logic supply_fault,
    input wire logic power_fail_irq_out,
    input wire logic power_fail_irq_oe
);
    logic [15:0] fault_cnt_reg;
    logic [15:0] stab_cnt_reg;
    logic [15:0] rel_cnt_reg;
    wire logic rd_mode = !bus.select_low_active_n && bus.select_high_active && bus.write_strobe_n
                         && !bus.output_enable_n;
    // Counters saturate so long runs never wrap
    always_ff @(posedge clock)
    begin
        if (!rstn || !supply_fault)
            fault_cnt_reg <= 16'h0000;
        else if (fault_cnt_reg != 16'hFFFF)
            fault_cnt_reg <= fault_cnt_reg + 16'h0001;
    end
    always_ff @(posedge clock)
    begin
        if (!rstn || !rd_mode || $changed(bus.address_lines))
            stab_cnt_reg <= 16'h0000;
        else if (stab_cnt_reg != 16'hFFFF)
            stab_cnt_reg <= stab_cnt_reg + 16'h0001;
    end
    always_ff @(posedge clock)
    begin
        if (!rstn || supply_fault || !power_fail_irq_oe)
            rel_cnt_reg <= 16'h0000;
        else if (rel_cnt_reg != 16'hFFFF)
            rel_cnt_reg <= rel_cnt_reg + 16'h0001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_irq_od; power_fail_irq_out == 1'b0; endproperty
    a_irq_od: assert property (p_irq_od) else $error("irq pin driven high");
    property p_irq_fast; $rose(supply_fault) |=> $rose(power_fail_irq_oe); endproperty
    a_irq_fast: assert property (p_irq_fast) else $error("irq late");
    property p_irq_release; rel_cnt_reg <= RELEASE_TICKS + 2; endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq held too long");
    property p_fault_float; fault_cnt_reg > DESELECT_TICKS + 1 |-> !data_lines_oe && !data_valid; endproperty
    a_fault_float: assert property (p_fault_float) else $error("drive while deselected");
    property p_recover_block;
        $fell(supply_fault) && fault_cnt_reg > DESELECT_TICKS + 1 |-> (!data_lines_oe) [*8];
    endproperty
    a_recover_block: assert property (p_recover_block) else $error("drive in recovery");
    property p_oe_cause;
        data_lines_oe |-> $past(!bus.select_low_active_n && bus.select_high_active && !bus.output_enable_n);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("drive without select");
    property p_valid_rd; data_valid |-> data_lines_oe && $past(rd_mode); endproperty
    a_valid_rd: assert property (p_valid_rd) else $error("valid outside read");
    property p_valid_late; $rose(data_valid) |-> stab_cnt_reg >= ACCESS_CYCLES - 2; endproperty
    a_valid_late: assert property (p_valid_late) else $error("valid too early");
    property p_addr_chg; data_valid && $changed(bus.address_lines) |-> ##[1:2] !data_valid; endproperty
    a_addr_chg: assert property (p_addr_chg) else $error("stale data kept");
endmodule : csb_clock_sram_asserts
bind csb_clock_sram csb_clock_sram_asserts #(.DESELECT_TICKS(DESELECT_TICKS), .RELEASE_TICKS(RELEASE_TICKS))
    u_asserts (.clock(clock), .rstn(rstn), .bus(bus), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .data_valid(data_valid),
    .supply_fault(supply_fault), .power_fail_irq_out(power_fail_irq_out), .power_fail_irq_oe(power_fail_irq_oe));

/* tb/test_clock_sram_bus_powerfail.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
// ****************************************
// Bench top
// ****************************************
module test_clock_sram_bus_powerfail;
    import csb_pkg::*;
    localparam int DESEL = 8;
    localparam int RECOV = 20;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic supply_fault = 1'b0;
    csb_bus_type bus;
    logic [7:0] host_dq, dout, rd_data, exp_v;
    logic oe, valid, irq_out, irq_oe, rd_done, rd_timeout;
    logic [7:0] exp_q[$];
    logic [31:0] r = 32'h3A94;
    logic [12:0] addr_list[8];
    logic [7:0] data_list[8];
    logic [7:0] tv[7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
    logic [7:0] tw[7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h99};
    logic [7:0] te[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h99};
    int error_cnt = 0;
    int comparisons = 0;
    // Shared data wire and pulled-up interrupt pin
    wire logic [7:0] dq = oe ? dout : host_dq;
    wire logic irq_pin_n = irq_oe ? irq_out : 1'b1;
    always #4 clock = ~clock;
    csb_clock_sram #(.DESELECT_TICKS(DESEL), .RELEASE_TICKS(10), .RECOVERY_TICKS(RECOV), .SECOND_TICKS(16)) dut (
        .clock(clock), .rstn(rstn), .bus(bus), .data_lines_in(dq), .data_lines_out(dout), .data_lines_oe(oe),
        .data_valid(valid), .supply_fault(supply_fault), .power_fail_irq_out(irq_out), .power_fail_irq_oe(irq_oe));
    csb_host_model host (.clock(clock), .data_lines_out(dq), .data_valid(valid), .bus(bus),
        .data_lines_in(host_dq), .rd_done(rd_done), .rd_data(rd_data), .rd_timeout(rd_timeout));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic test_done();
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic rdx(input logic [12:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask : rdx
    always @(posedge clock)
    begin
        if (rd_timeout === 1'b1)
        begin
            `CHK("read timeout", 1'b0, rd_timeout)
            test_done();
        end
        else if (rd_done === 1'b1)
        begin
            exp_v = exp_q.pop_front();
            `CHK("read data", exp_v, rd_data)
        end
    end
    initial
    begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        // Random bytes at distinct addresses, both ends of plain memory, back to back
        for (int i = 0; i < 8; i++)
        begin
            r = lfsr(r);
            addr_list[i] = (i == 0) ? 13'h0000 : (i == 7) ? 13'h1FF7 : {1'b0, r[8:0], 3'(i)};
            data_list[i] = r[23:16];
            host.wr(addr_list[i], data_list[i]);
        end
        for (int i = 0; i < 8; i++)
            rdx(addr_list[i], data_list[i]);
        // Halted clock bytes read back as written, zero bits kept zero
        host.wr(CONTROL_ADDR, 8'h65); // Read bit, sign, calibration
        for (int i = 0; i < 7; i++)
            host.wr(SECONDS_ADDR + 13'(i), tv[i]); // Test bit left zero
        rdx(CONTROL_ADDR, 8'h65);
        for (int i = 0; i < 7; i++)
            rdx(SECONDS_ADDR + 13'(i), tv[i]);
        // Load counters on write-bit clear, let one tick pass, then freeze
        host.wr(CONTROL_ADDR, 8'h80);
        for (int i = 0; i < 7; i++)
            host.wr(SECONDS_ADDR + 13'(i), tw[i]);
        host.wr(CONTROL_ADDR, 8'h00);
        repeat (20) @(posedge clock);
        host.wr(CONTROL_ADDR, 8'h40);
        for (int i = 0; i < 7; i++)
            rdx(SECONDS_ADDR + 13'(i), te[i]);
        // Supply fault with writes during deselect and recovery
        @(posedge clock);
        supply_fault <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK("irq pin", 1'b0, irq_pin_n)
        repeat (DESEL + 2) @(posedge clock);
        host.wr(addr_list[1], ~data_list[1]);
        `CHK("drive in fault", 1'b0, oe)
        @(posedge clock);
        supply_fault <= 1'b0;
        host.wr(addr_list[2], ~data_list[2]); // Deliberate write inside recovery
        repeat (RECOV) @(posedge clock); // Host idle while supply returns
        `CHK("irq pin", 1'b1, irq_pin_n)
        rdx(addr_list[1], data_list[1]);
        rdx(addr_list[2], data_list[2]);
        repeat (4) @(posedge clock);
        test_done();
    end
endmodule : test_clock_sram_bus_powerfail
